/* pkg/clpd_regs.svh */
/*
   Constants of the load detect block: offsets, fields, resets, pin patterns, timing.
   Assumes inclusion by bare name.
*/
`ifndef CLPD_REGS_SVH
`define CLPD_REGS_SVH

// clock rate in kHz and timing figures in ms
`define CLPD_CLK_KHZ 50000
`define CLPD_T_PW_IDLE_MS 15000
`define CLPD_T_WAKE_DIS_MS 2000
`define CLPD_T_LP_SET_MS 200
`define CLPD_T_LP_CLR_MS 3000
`define CLPD_T_AUTO_DIS_MS 1000

// register byte offsets
`define CLPD_REG_CTRL 8'h00
`define CLPD_REG_STATUS 8'h04
`define CLPD_REG_IRQ_STAT 8'h08
`define CLPD_REG_IRQ_MASK 8'h0C

// field positions
`define CLPD_CTRL_AUTO_EN_BIT 0
`define CLPD_STAT_MODE_LSB 0
`define CLPD_STAT_STATE_LSB 4
`define CLPD_STAT_LP_BIT 8
`define CLPD_STAT_LIMIT_LSB 12
`define CLPD_STAT_ROLE_LSB 16
`define CLPD_EV_LP_SET 0
`define CLPD_EV_LP_CLR 1
`define CLPD_EV_WAKE 2
`define CLPD_EV_AUTO 3

// reset values
`define CLPD_CTRL_AUTO_EN_RST 1'b1
`define CLPD_IRQ_MASK_RST 4'h0

// mode pin patterns {mode_pin_a, mode_pin_b, mode_pin_c, limit_select}
`define CLPD_PAT_PW 4'h3
`define CLPD_PAT_DCP_LD 4'h7
`define CLPD_PAT_DATA_PORT_LOW_LIMIT_VARIANT 4'hE
`define CLPD_PAT_CDP 4'hF

// bus responses
`define CLPD_RESP_OKAY 2'h0
`define CLPD_RESP_SLVERR 2'h2

`endif

/* pkg/clpd_pkg.sv */
/*
   Types of the load detect block.
   Assumes nothing of its surroundings.
*/
package clpd_pkg;

   typedef enum logic [2:0] {
      ST_RUN = 3'h0,
      ST_LOWPWR = 3'h1,
      ST_WAKE_DIS = 3'h3,
      ST_AUTO_DIS = 3'h2,
      ST_AUTO_SDP = 3'h6,
      ST_OFF = 3'h4
   } clpd_state_e;

   typedef enum logic [1:0] {
      LIM_NONE = 2'h0,
      LIM_LOW = 2'h1,
      LIM_HIGH = 2'h2,
      LIM_INTERNAL = 2'h3
   } clpd_limit_e;

   typedef enum logic [2:0] {
      ROLE_NONE = 3'h0,
      ROLE_SDP = 3'h1,
      ROLE_CDP = 3'h2,
      ROLE_DCP = 3'h3,
      ROLE_DIVIDER = 3'h4
   } clpd_role_e;

   typedef struct packed {
      logic mode_pin_a;
      logic mode_pin_b;
      logic mode_pin_c;
      logic limit_select;
   } clpd_mode_s;

   typedef struct packed {
      logic below_idle;
      logic at_internal_limit;
      logic above_lo_plus;
      logic below_lo_minus;
      logic primary_detect;
      logic dcp_misclass;
      logic sdp_connected;
   } clpd_sense_s;

   typedef struct packed {
      logic power_on;
      logic discharge;
      clpd_limit_e limit;
      clpd_role_e role;
   } clpd_port_s;

   typedef struct packed {
      logic [29:0] cnt;
      logic done;
   } clpd_tmr_s;

   typedef struct packed {
      clpd_mode_s mode_s1;
      clpd_mode_s mode_s2;
      clpd_sense_s sense_s1;
      clpd_sense_s sense_s2;
      clpd_state_e st;
      logic [29:0] dis_cnt;
      logic lp;
      clpd_port_s port;
      logic auto_en;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
      logic irq;
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } clpd_state_s;

endpackage

/* verilog/clpd_qual_timer.sv */
/*
   Qualification timer: done once cond held CYCLES clocks, while cond holds.
   Assumes cond comes from logic on aclk.
*/
`timescale 1ns/1ns

module clpd_qual_timer #(
   parameter int unsigned CYCLES = 1
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // condition and result
   input wire logic cond,
   output logic done
);

   localparam logic [29:0] LAST = 30'(CYCLES - 1);

   clpd_pkg::clpd_tmr_s q;
   clpd_pkg::clpd_tmr_s d;

   always_comb
   begin
      d = q;
      if (!cond)
      begin
         d.cnt = 30'h0;
         d.done = 1'b0;
      end
      else if (!q.done)
      begin
         if (q.cnt == LAST)
         begin
            d.done = 1'b1;
         end
         else
         begin
            d.cnt = q.cnt + 30'h1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign done = q.done;

endmodule

/* verilog/clpd_load_detect.sv */
/*
   Load detect and port mode logic: power wake, port power status, CDP/SDP auto switch.
   Assumes asynchronous comparator levels and mode pins from a system controller.
*/
`timescale 1ns/1ns

`include "clpd_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - in power wake, load below 45mA over 15s selects 55mA limit, releases status.
// - in low power state, load hitting internal limit drives status low.
// - after wake, discharge output over 2s, then re-enable with high limit.
// - power wake only on pattern 0011; status held low while charging.
// - CDP/DCP: assert status after load above low limit plus 25mA for 200ms.
// - CDP/DCP: release status after load below low limit minus 25mA for 3s.
// - status threshold is no limit; charging CDP/DCP keeps the high limit.
// - pattern 1110 to 1111 enters CDP without discharging the output.
// - non-charging role works as SDP with the low limit.
// - CDP: phone took port as DCP without data; discharge and reconfigure as SDP.
// - after phone connects as SDP, return to CDP without discharge.
// - power wake limit follows load state between internal and high limit.
// - CDP asserts status on thresholds or on a primary detection.
module clpd_load_detect #(
   parameter int unsigned PW_IDLE_CYC = `CLPD_T_PW_IDLE_MS * `CLPD_CLK_KHZ,
   parameter int unsigned WAKE_DIS_CYC = `CLPD_T_WAKE_DIS_MS * `CLPD_CLK_KHZ,
   parameter int unsigned LP_SET_CYC = `CLPD_T_LP_SET_MS * `CLPD_CLK_KHZ,
   parameter int unsigned LP_CLR_CYC = `CLPD_T_LP_CLR_MS * `CLPD_CLK_KHZ,
   parameter int unsigned AUTO_DIS_CYC = `CLPD_T_AUTO_DIS_MS * `CLPD_CLK_KHZ
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // mode pins and analog sense levels
   input wire clpd_pkg::clpd_mode_s mode_pins,
   input wire clpd_pkg::clpd_sense_s sense,
   // port outputs
   output logic load_present_n,
   output clpd_pkg::clpd_port_s port_ctl,
   output logic irq,
   // write address
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   // write data
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   // write response
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // read address
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   // read data
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp
);

   localparam logic [29:0] WAKE_LOAD = 30'(WAKE_DIS_CYC);
   localparam logic [29:0] AUTO_LOAD = 30'(AUTO_DIS_CYC);
   localparam int unsigned TMR_CYC [3] = '{PW_IDLE_CYC, LP_SET_CYC, LP_CLR_CYC};

   clpd_pkg::clpd_state_s q;
   clpd_pkg::clpd_state_s d;

   logic [3:0] pat;
   logic pw_mode;
   logic ld_mode;
   logic cdp_mode;
   logic off_mode;
   logic [2:0] tmr_cond;
   logic [2:0] tmr_done;
   logic [3:0] ev;
   logic [3:0] clr;
   logic [31:0] rd;

   /////////////////////////////////////////////////////////////////////////////
   // mode decode from synchronised pins

   assign pat = q.mode_s2;
   assign pw_mode = (pat == `CLPD_PAT_PW);
   assign cdp_mode = (pat == `CLPD_PAT_CDP);
   assign ld_mode = cdp_mode || (pat == `CLPD_PAT_DCP_LD);
   assign off_mode = (pat[3:1] == 3'h0);

   /////////////////////////////////////////////////////////////////////////////
   // qualification timers: power wake idle, status set, status release

   assign tmr_cond[0] = pw_mode && (q.st == clpd_pkg::ST_RUN) && q.sense_s2.below_idle;
   assign tmr_cond[1] = ld_mode && q.sense_s2.above_lo_plus;
   assign tmr_cond[2] = ld_mode && q.sense_s2.below_lo_minus;

   generate
      for (genvar gi = 0; gi < 3; gi++)
      begin : g_tmr
         clpd_qual_timer #(
            .CYCLES(TMR_CYC[gi])
         ) u_tmr (
            .aclk(aclk),
            .aresetn(aresetn),
            .cond(tmr_cond[gi]),
            .done(tmr_done[gi])
         );
      end
   endgenerate

   /////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      d = q;
      ev = 4'h0;
      clr = 4'h0;
      rd = 32'h0;

      d.mode_s1 = mode_pins;
      d.mode_s2 = q.mode_s1;
      d.sense_s1 = sense;
      d.sense_s2 = q.sense_s1;

      // port state machine
      case (q.st)
         clpd_pkg::ST_OFF:
         begin
            d.st = clpd_pkg::ST_RUN;
         end
         clpd_pkg::ST_RUN:
         begin
            if (pw_mode && tmr_done[0])
            begin
               d.st = clpd_pkg::ST_LOWPWR;
            end
            else if (cdp_mode && q.auto_en && q.sense_s2.dcp_misclass)
            begin
               d.st = clpd_pkg::ST_AUTO_DIS;
               d.dis_cnt = AUTO_LOAD;
               ev[`CLPD_EV_AUTO] = 1'b1;
            end
         end
         clpd_pkg::ST_LOWPWR:
         begin
            if (!pw_mode)
            begin
               d.st = clpd_pkg::ST_RUN;
            end
            else if (q.sense_s2.at_internal_limit)
            begin
               d.st = clpd_pkg::ST_WAKE_DIS;
               d.dis_cnt = WAKE_LOAD;
               ev[`CLPD_EV_WAKE] = 1'b1;
            end
         end
         clpd_pkg::ST_WAKE_DIS:
         begin
            // holds load+1 cycles, so strictly longer than the figure
            if (!pw_mode || (q.dis_cnt == 30'h0))
            begin
               d.st = clpd_pkg::ST_RUN;
            end
            else
            begin
               d.dis_cnt = q.dis_cnt - 30'h1;
            end
         end
         clpd_pkg::ST_AUTO_DIS:
         begin
            if (!cdp_mode)
            begin
               d.st = clpd_pkg::ST_RUN;
            end
            else if (q.dis_cnt == 30'h0)
            begin
               d.st = clpd_pkg::ST_AUTO_SDP;
            end
            else
            begin
               d.dis_cnt = q.dis_cnt - 30'h1;
            end
         end
         clpd_pkg::ST_AUTO_SDP:
         begin
            if (!cdp_mode || q.sense_s2.sdp_connected)
            begin
               d.st = clpd_pkg::ST_RUN;
            end
         end
         default:
         begin
            d.st = clpd_pkg::ST_OFF;
         end
      endcase
      if (off_mode)
      begin
         d.st = clpd_pkg::ST_OFF;
      end

      // load present
      if (pw_mode)
      begin
         d.lp = (d.st != clpd_pkg::ST_LOWPWR);
      end
      else if (ld_mode)
      begin
         if (tmr_done[1] || (cdp_mode && q.sense_s2.primary_detect))
         begin
            d.lp = 1'b1;
         end
         else if (tmr_done[2])
         begin
            d.lp = 1'b0;
         end
      end
      else
      begin
         d.lp = 1'b0;
      end
      ev[`CLPD_EV_LP_SET] = d.lp && !q.lp;
      ev[`CLPD_EV_LP_CLR] = !d.lp && q.lp;

      // port control; discharge only in off and the two discharge states
      d.port.discharge = (d.st == clpd_pkg::ST_OFF) || (d.st == clpd_pkg::ST_WAKE_DIS)
                         || (d.st == clpd_pkg::ST_AUTO_DIS);
      d.port.power_on = !d.port.discharge;
      d.port.role = clpd_pkg::ROLE_NONE;
      d.port.limit = clpd_pkg::LIM_NONE;
      if (!d.port.discharge)
      begin
         case (pat[3:1])
            3'h1:
            begin
               d.port.role = clpd_pkg::ROLE_DCP;
               d.port.limit = clpd_pkg::LIM_HIGH;
               if (pw_mode && (d.st == clpd_pkg::ST_LOWPWR))
               begin
                  d.port.limit = clpd_pkg::LIM_INTERNAL;
               end
            end
            3'h3:
            begin
               d.port.role = clpd_pkg::ROLE_DCP;
               d.port.limit = clpd_pkg::LIM_HIGH;
            end
            3'h4:
            begin
               d.port.role = clpd_pkg::ROLE_DCP;
               d.port.limit = pat[0] ? clpd_pkg::LIM_HIGH : clpd_pkg::LIM_LOW;
            end
            3'h5:
            begin
               d.port.role = clpd_pkg::ROLE_DIVIDER;
               d.port.limit = pat[0] ? clpd_pkg::LIM_HIGH : clpd_pkg::LIM_LOW;
            end
            3'h7:
            begin
               if (cdp_mode && (d.st != clpd_pkg::ST_AUTO_SDP))
               begin
                  d.port.role = clpd_pkg::ROLE_CDP;
                  d.port.limit = clpd_pkg::LIM_HIGH;
               end
               else
               begin
                  d.port.role = clpd_pkg::ROLE_SDP;
                  d.port.limit = cdp_mode ? clpd_pkg::LIM_HIGH : clpd_pkg::LIM_LOW;
               end
            end
            default:
            begin
               d.port.role = clpd_pkg::ROLE_SDP;
               d.port.limit = pat[0] ? clpd_pkg::LIM_HIGH : clpd_pkg::LIM_LOW;
            end
         endcase
      end

      /////////////////////////////////////////////////////////////////////////
      // register bus: write address and data in any order, then response

      if (s_axi_awvalid && s_axi_awready)
      begin
         d.aw_got = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         d.w_got = 1'b1;
         d.w_data = s_axi_wdata;
         d.w_strb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready)
      begin
         d.bvalid = 1'b0;
      end
      if (q.aw_got && q.w_got && !q.bvalid)
      begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = `CLPD_RESP_OKAY;
         case (q.aw_addr)
            `CLPD_REG_CTRL:
            begin
               if (q.w_strb[0])
               begin
                  d.auto_en = q.w_data[`CLPD_CTRL_AUTO_EN_BIT];
               end
            end
            `CLPD_REG_STATUS:
            begin
            end
            `CLPD_REG_IRQ_STAT:
            begin
               if (q.w_strb[0])
               begin
                  clr = q.w_data[3:0];
               end
            end
            `CLPD_REG_IRQ_MASK:
            begin
               if (q.w_strb[0])
               begin
                  d.irq_mask = q.w_data[3:0];
               end
            end
            default:
            begin
               d.bresp = `CLPD_RESP_SLVERR;
            end
         endcase
      end

      // a new event wins over a clear in the same cycle
      d.irq_stat = (q.irq_stat & ~clr) | ev;
      d.irq = |(d.irq_stat & d.irq_mask);

      // read
      if (q.rvalid && s_axi_rready)
      begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
         d.rvalid = 1'b1;
         d.rresp = `CLPD_RESP_OKAY;
         case (s_axi_araddr)
            `CLPD_REG_CTRL:
            begin
               rd[`CLPD_CTRL_AUTO_EN_BIT] = q.auto_en;
            end
            `CLPD_REG_STATUS:
            begin
               rd[`CLPD_STAT_MODE_LSB +: 4] = pat;
               rd[`CLPD_STAT_STATE_LSB +: 3] = q.st;
               rd[`CLPD_STAT_LP_BIT] = q.lp;
               rd[`CLPD_STAT_LIMIT_LSB +: 2] = q.port.limit;
               rd[`CLPD_STAT_ROLE_LSB +: 3] = q.port.role;
            end
            `CLPD_REG_IRQ_STAT:
            begin
               rd[3:0] = q.irq_stat;
            end
            `CLPD_REG_IRQ_MASK:
            begin
               rd[3:0] = q.irq_mask;
            end
            default:
            begin
               d.rresp = `CLPD_RESP_SLVERR;
            end
         endcase
         d.rdata = rd;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q <= '0;
         q.st <= clpd_pkg::ST_OFF;
         q.auto_en <= `CLPD_CTRL_AUTO_EN_RST;
         q.irq_mask <= `CLPD_IRQ_MASK_RST;
      end
      else
      begin
         q <= d;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // outputs

   assign load_present_n = !q.lp;
   assign port_ctl = q.port;
   assign irq = q.irq;
   assign s_axi_awready = !q.aw_got && !q.bvalid;
   assign s_axi_wready = !q.w_got && !q.bvalid;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;

endmodule

/* verif/clpd_load_detect_properties.sv */
/*
   Checker of the load detect block.
   Assumes binding into clpd_load_detect.
*/
`timescale 1ns/1ns
`include "clpd_regs.svh"

module clpd_load_detect_checker #(
   parameter int unsigned PW_IDLE_CYC = 1,
   parameter int unsigned WAKE_DIS_CYC = 1,
   parameter int unsigned LP_CLR_CYC = 1
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // pins and port outputs
   input wire clpd_pkg::clpd_mode_s mode_pins,
   input wire clpd_pkg::clpd_sense_s sense,
   input wire logic load_present_n,
   input wire clpd_pkg::clpd_port_s port_ctl,
   // bus responses
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   logic [31:0] idle_q;
   logic [31:0] lo_q;
   logic [31:0] dis_q;

   ////////////////////////////////////////
   // run lengths of raw sense levels and of the discharge output
   always_ff @(posedge aclk)
   begin
      idle_q <= sense.below_idle ? idle_q + 32'h1 : 32'h0;
      lo_q <= sense.below_lo_minus ? lo_q + 32'h1 : 32'h0;
      dis_q <= port_ctl.discharge ? dis_q + 32'h1 : 32'h0;
   end

   ////////////////////////////////////////
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("bvalid dropped");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("rvalid dropped");
   a_one_resp: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_idle_wait: assert property ($rose(load_present_n) && mode_pins == `CLPD_PAT_PW
      && $past(mode_pins, 6) == `CLPD_PAT_PW |-> $past(idle_q) >= PW_IDLE_CYC
      && port_ctl.limit == clpd_pkg::LIM_INTERNAL) else $error("low power entered early");
   a_wake_on_limit: assert property ($rose(sense.at_internal_limit)
      && port_ctl.limit == clpd_pkg::LIM_INTERNAL && mode_pins == `CLPD_PAT_PW
      |-> ##[1:5] (!load_present_n && port_ctl.discharge)) else $error("no wake on limit");
   a_wake_dis_len: assert property ($fell(port_ctl.discharge) && !$past(load_present_n)
      && mode_pins == `CLPD_PAT_PW |-> dis_q > WAKE_DIS_CYC)
      else $error("wake discharge short");
   a_lp_clr_wait: assert property ($rose(load_present_n) && mode_pins == `CLPD_PAT_CDP
      && $past(mode_pins, 6) == `CLPD_PAT_CDP |-> $past(lo_q) >= LP_CLR_CYC)
      else $error("load flag released early");
   a_charge_limit: assert property (!load_present_n && !port_ctl.discharge
      && port_ctl.role == clpd_pkg::ROLE_CDP |-> port_ctl.limit == clpd_pkg::LIM_HIGH)
      else $error("charging port not on high limit");
   a_sdp_low: assert property ((mode_pins == `CLPD_PAT_DATA_PORT_LOW_LIMIT_VARIANT) [*8]
      |-> port_ctl.role == clpd_pkg::ROLE_SDP && port_ctl.limit == clpd_pkg::LIM_LOW)
      else $error("data role not on low limit");
   a_cdp_no_dis: assert property ((mode_pins == `CLPD_PAT_DATA_PORT_LOW_LIMIT_VARIANT) [*8]
      ##1 (mode_pins == `CLPD_PAT_CDP) |=> !port_ctl.discharge [*5])
      else $error("discharge on return to charging");
endmodule

bind clpd_load_detect clpd_load_detect_checker #(
   .PW_IDLE_CYC(PW_IDLE_CYC),
   .WAKE_DIS_CYC(WAKE_DIS_CYC),
   .LP_CLR_CYC(LP_CLR_CYC)
) chk_i (
   .aclk(aclk),
   .aresetn(aresetn),
   .mode_pins(mode_pins),
   .sense(sense),
   .load_present_n(load_present_n),
   .port_ctl(port_ctl),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_bresp(s_axi_bresp),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata)
);

/* verif/clpd_sys_ctrl_model.sv */
/*
   System controller model: mode pins of one port, data role while another charges.
   Assumes the other port's load flag comes from the bench.
*/
`timescale 1ns/1ns
`include "clpd_regs.svh"

module clpd_sys_ctrl_model (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // requested mode and other port's load flag
   input wire clpd_pkg::clpd_mode_s base_mode,
   input wire logic other_charging,
   // watched status and driven pins
   input wire logic load_present_n,
   output clpd_pkg::clpd_mode_s mode_pins
);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mode_pins <= '0;
      end
      else if (other_charging && load_present_n && base_mode == `CLPD_PAT_CDP)
      begin
         mode_pins <= clpd_pkg::clpd_mode_s'(`CLPD_PAT_DATA_PORT_LOW_LIMIT_VARIANT);
      end
      else
      begin
         mode_pins <= base_mode;
      end
   end
endmodule

/* verif/tb_clpd_load_detect.sv */
/*
   Testbench of the load detect block with short timers.
   Assumes the bound checker and the controller model.
*/
`timescale 1ns/1ns
`include "clpd_regs.svh"

module tb_clpd_load_detect;
   localparam int unsigned PW = 20;
   localparam int unsigned WD = 10;
   localparam int unsigned LS = 8;
   localparam int unsigned LC = 12;
   localparam int unsigned AD = 6;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   clpd_pkg::clpd_mode_s base_mode = '0;
   logic other_charging = 1'b0;
   clpd_pkg::clpd_mode_s mode_pins;
   clpd_pkg::clpd_sense_s sense = '0;
   logic load_present_n;
   clpd_pkg::clpd_port_s port_ctl;
   logic irq;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [1:0] bresp, rresp, r;
   int err_total = 0;
   int num_checks = 0;

   always #10 aclk = ~aclk;

   clpd_sys_ctrl_model ctl_i (.aclk(aclk), .aresetn(aresetn), .base_mode(base_mode),
      .other_charging(other_charging), .load_present_n(load_present_n),
      .mode_pins(mode_pins));

   clpd_load_detect #(.PW_IDLE_CYC(PW), .WAKE_DIS_CYC(WD), .LP_SET_CYC(LS),
      .LP_CLR_CYC(LC), .AUTO_DIS_CYC(AD)) uut (.aclk(aclk), .aresetn(aresetn),
      .mode_pins(mode_pins), .sense(sense), .load_present_n(load_present_n),
      .port_ctl(port_ctl), .irq(irq), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));

   ////////////////////////////////////////
   task automatic ck(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      fork
         begin
            do @(posedge aclk); while (!awready);
            awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (!wready);
            wvalid <= 1'b0;
         end
      join
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
      ck("bresp", 32'(bresp), 32'(e));
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      v = rdata;
      e = rresp;
      rready <= 1'b0;
   endtask

   ////////////////////////////////////////
   task automatic t_regs;
      ck("lp_n rst", 32'(load_present_n), 32'h1);
      ck("irq rst", 32'(irq), 32'h0);
      rd(`CLPD_REG_CTRL, d, r);
      ck("ctrl", d, 32'h1);
      rd(`CLPD_REG_IRQ_MASK, d, r);
      ck("mask", d, 32'h0);
      rd(8'h10, d, r);
      ck("unmap resp", 32'(r), 32'(`CLPD_RESP_SLVERR));
      ck("unmap data", d, 32'h0);
      wr(8'h10, 32'h1, `CLPD_RESP_SLVERR);
      wr(`CLPD_REG_STATUS, 32'hFFFF_FFFF, `CLPD_RESP_OKAY);
   endtask

   task automatic t_wake;
      base_mode <= `CLPD_PAT_PW;
      cyc(10);
      ck("lp_n run", 32'(load_present_n), 32'h0);
      ck("lim run", 32'(port_ctl.limit), 32'(clpd_pkg::LIM_HIGH));
      sense.below_idle <= 1'b1;
      cyc(PW - 2);
      sense.below_idle <= 1'b0;
      cyc(1);
      sense.below_idle <= 1'b1;
      cyc(PW);
      ck("idle restart", 32'(load_present_n), 32'h0);
      cyc(8);
      ck("lp_n idle", 32'(load_present_n), 32'h1);
      ck("lim idle", 32'(port_ctl.limit), 32'(clpd_pkg::LIM_INTERNAL));
      sense.below_idle <= 1'b0;
      sense.at_internal_limit <= 1'b1;
      cyc(5);
      ck("lp_n wake", 32'(load_present_n), 32'h0);
      ck("dis wake", 32'({port_ctl.power_on, port_ctl.discharge}), 32'h1);
      cyc(7);
      ck("dis hold", 32'(port_ctl.discharge), 32'h1);
      cyc(8);
      sense.at_internal_limit <= 1'b0;
      ck("dis end", 32'({port_ctl.power_on, port_ctl.discharge}), 32'h2);
      ck("lim back", 32'(port_ctl.limit), 32'(clpd_pkg::LIM_HIGH));
   endtask

   task automatic t_cdp;
      base_mode <= `CLPD_PAT_CDP;
      sense.below_lo_minus <= 1'b1;
      cyc(LC + 8);
      ck("lp_n clr0", 32'(load_present_n), 32'h1);
      sense.below_lo_minus <= 1'b0;
      sense.above_lo_plus <= 1'b1;
      cyc(LS - 2);
      sense.above_lo_plus <= 1'b0;
      ck("set early", 32'(load_present_n), 32'h1);
      cyc(1);
      sense.above_lo_plus <= 1'b1;
      cyc(LS);
      ck("set restart", 32'(load_present_n), 32'h1);
      cyc(6);
      ck("lp_n set", 32'(load_present_n), 32'h0);
      ck("lim charge", 32'(port_ctl.limit), 32'(clpd_pkg::LIM_HIGH));
      sense.above_lo_plus <= 1'b0;
      sense.below_lo_minus <= 1'b1;
      cyc(LC);
      ck("clr early", 32'(load_present_n), 32'h0);
      cyc(6);
      ck("lp_n clr", 32'(load_present_n), 32'h1);
      other_charging <= 1'b1;
      cyc(10);
      ck("role data", 32'(port_ctl.role), 32'(clpd_pkg::ROLE_SDP));
      ck("lim data", 32'(port_ctl.limit), 32'(clpd_pkg::LIM_LOW));
      other_charging <= 1'b0;
      cyc(8);
      ck("role back", 32'(port_ctl.role), 32'(clpd_pkg::ROLE_CDP));
      sense.below_lo_minus <= 1'b0;
      sense.primary_detect <= 1'b1;
      cyc(6);
      ck("lp_n primary", 32'(load_present_n), 32'h0);
      sense.primary_detect <= 1'b0;
      sense.below_lo_minus <= 1'b1;
      cyc(LC + 8);
   endtask

   task automatic t_auto;
      rd(`CLPD_REG_IRQ_STAT, d, r);
      ck("stat wake", d & 32'h6, 32'h6);
      wr(`CLPD_REG_IRQ_MASK, 32'h8, `CLPD_RESP_OKAY);
      cyc(2);
      ck("irq masked", 32'(irq), 32'h0);
      sense.dcp_misclass <= 1'b1;
      cyc(5);
      sense.dcp_misclass <= 1'b0;
      ck("auto dis", 32'(port_ctl.discharge), 32'h1);
      ck("irq auto", 32'(irq), 32'h1);
      cyc(AD + 3);
      ck("auto role", 32'({port_ctl.discharge, port_ctl.role}), 32'(clpd_pkg::ROLE_SDP));
      sense.sdp_connected <= 1'b1;
      cyc(5);
      sense.sdp_connected <= 1'b0;
      ck("auto back", 32'({port_ctl.discharge, port_ctl.role}), 32'(clpd_pkg::ROLE_CDP));
      wr(`CLPD_REG_IRQ_STAT, 32'hF, `CLPD_RESP_OKAY);
      cyc(3);
      ck("irq clear", 32'(irq), 32'h0);
      wr(`CLPD_REG_CTRL, 32'h0, `CLPD_RESP_OKAY);
      sense.dcp_misclass <= 1'b1;
      cyc(8);
      sense.dcp_misclass <= 1'b0;
      ck("auto off", 32'({port_ctl.discharge, port_ctl.role}), 32'(clpd_pkg::ROLE_CDP));
   endtask

   ////////////////////////////////////////
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      cyc(16);
      aresetn <= 1'b1;
      cyc(1);
      t_regs;
      t_wake;
      t_cdp;
      t_auto;
      conclude;
   end

   initial
   begin
      cyc(20000);
      err_total++;
      conclude;
   end
endmodule
